// *** tb.sv ***
// Self-checking bench for the output frame formatter
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [30:0] PAT = 31'h5A3C0F96;
  logic        clk_i, resetn_i, sample_valid_i, sample_ready_o, ser_o, oh_vld;
  logic        bit_stb_o, word_stb_o, minor_stb_o, major_stb_o, underrun_o;
  logic [4:0]  ch_ports_i, served_port_o;
  logic [30:0] crc_en_i, stuff_data_i, sample_data_i, gclk_o, chan;
  logic [61:0] stuff_req_i;
  logic [28:0] oh;
  logic [5:0]  wlen;
  int          n_fail, compares, c1, c3, c1_last, c3_last;
  tdm_output_frame_formatter u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ch_ports_i(ch_ports_i),
    .crc_en_i(crc_en_i), .stuff_req_i(stuff_req_i), .stuff_data_i(stuff_data_i), .sample_data_i(sample_data_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .ser_o(ser_o), .bit_stb_o(bit_stb_o),
    .word_stb_o(word_stb_o), .minor_stb_o(minor_stb_o), .major_stb_o(major_stb_o), .gclk_o(gclk_o),
    .served_port_o(served_port_o), .underrun_o(underrun_o));
  tdm_demux_model u_far (.clk_i(clk_i), .resetn_i(resetn_i), .ser_i(ser_o), .bit_i(bit_stb_o),
    .word_i(word_stb_o), .minor_i(minor_stb_o), .oh_o(oh), .oh_vld_o(oh_vld), .chan_o(chan), .wlen_o(wlen));
  // ==========================================================
  // Clock and gated clock tallies per minor frame
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (minor_stb_o) begin
      c1_last <= c1;
      c3_last <= c3;
      c1 <= 0;
      c3 <= 0;
    end else begin
      c1 <= c1 + int'(gclk_o[1]);
      c3 <= c3 + int'(gclk_o[3]);
    end
  // ==========================================================
  // Compare and verdict
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Fill the FIFO until it refuses; feed stays on so it never runs dry
  task automatic t_fill;
    int n;
    n = 0;
    sample_valid_i = 1'b1;
    while (sample_ready_o === 1'b1 && n < 40) begin
      n++;
      @(posedge clk_i);
      #10;
    end
    check("fifo words taken", 32'h1, 32'(n >= 16 && n <= 17));
  endtask
  // Four overhead words: none, positive, negative, reserved-as-none
  task automatic t_oh;
    int k;
    logic [22:0] code;
    for (int m = 0; m < 4; m++) begin
      k = 0;
      while (oh_vld !== 1'b1 && k < 5000) begin
        @(posedge clk_i);
        #1;
        k++;
      end
      code = (m == 1) ? tdm_pkg::CODE_POS : (m == 2) ? tdm_pkg::CODE_NEG : tdm_pkg::CODE_NONE;
      check("overhead word", {3'h0, m == 1, 5'(m), code}, {3'h0, oh});
      check("port1 clocks", 32'(m == 1 ? 30 : 29), 32'(c1_last));
      check("port3 clocks", 32'd28, 32'(c3_last));
      check("channel bits", {1'b0, PAT}, {1'b0, chan});
      check("word bits", 32'd32, 32'(wlen));
      @(posedge clk_i);
      #1;
    end
  endtask
  // Stop the feed: FIFO drains, underrun rises and zeros go out
  task automatic t_drain;
    int k;
    @(posedge clk_i);
    #10;
    sample_valid_i = 1'b0;
    k = 0;
    while (underrun_o !== 1'b1 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    check("underrun", 32'h1, 32'(underrun_o === 1'b1));
    repeat (2) @(posedge word_stb_o);
    repeat (2) @(posedge clk_i);
    #1;
    check("idle channel bits", 32'h0, {1'b0, chan});
    check("ready when empty", 32'h1, 32'(sample_ready_o === 1'b1));
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {n_fail, compares, c1, c3, c1_last, c3_last} = '0;
    resetn_i = 1'b0;
    sample_valid_i = 1'b0;
    ch_ports_i = 5'h1F;
    crc_en_i = 31'h00000008;
    stuff_data_i = 31'h7FFFFFFF;
    sample_data_i = PAT;
    stuff_req_i = 62'h00000000000000E4;
    repeat (8) @(posedge clk_i);
    #10;
    resetn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #10;
    t_fill();
    t_oh();
    t_drain();
    print_verdict();
  end
  initial begin
    #4000000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire

// *** tdm_demux_model.sv ***
// Far-end receiver model: rebuilds overhead words and channel bits
`timescale 1ns/1ns
`default_nettype none
module tdm_demux_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ser_i,
  input  wire logic        bit_i,
  input  wire logic        word_i,
  input  wire logic        minor_i,
  output logic      [28:0] oh_o,
  output logic             oh_vld_o,
  output logic      [30:0] chan_o,
  output logic      [5:0]  wlen_o
);
  logic [28:0] oh_reg;
  logic [30:0] cur_reg;
  logic [4:0]  wi_reg;
  logic [5:0]  bi_reg;
  logic        sync_reg;
  // ==========================================================
  // Receiver
  // Sense bit is dropped unless the code says positive stuff
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) begin
      {oh_reg, cur_reg, wi_reg, bi_reg, sync_reg, oh_o, oh_vld_o, chan_o, wlen_o} <= '0;
    end else begin
      oh_vld_o <= bit_i & word_i & minor_i & sync_reg;
      if (bit_i & word_i) begin
        wi_reg <= minor_i ? 5'h01 : wi_reg + 5'h01;
        oh_reg[minor_i ? 5'h00 : wi_reg] <= ser_i;
        sync_reg <= sync_reg | minor_i;
        if (minor_i) oh_o <= {oh_reg[28] & (oh_reg[22:0] == tdm_pkg::CODE_POS), oh_reg[27:0]};
        chan_o <= cur_reg;
        wlen_o <= bi_reg + 6'h01;
        bi_reg <= 6'h00;
      end else if (bit_i) begin
        cur_reg[bi_reg[4:0]] <= ser_i;
        bi_reg <= bi_reg + 6'h01;
      end
    end
endmodule
`default_nettype wire

// *** tdm_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module tdm_fifo #(
  parameter int unsigned WIDTH = 31,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  // Flags follow the count, so full and empty are never stale
  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];
  // ==========================================================================
  // Storage and pointers
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push != pop) count_reg <= push ? count_reg + 1'b1 : count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tdm_output_frame_formatter.sv ***
// Serial output frame formatter: channel bits interleaved with overhead
`timescale 1ns/1ns
`default_nettype none
module tdm_output_frame_formatter (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Channel port count N, taken at each major frame start
  input  wire logic [4:0]  ch_ports_i,
  // Ports under coarse rate conversion
  input  wire logic [30:0] crc_en_i,
  // Two-bit stuff request per port, port p at bits 2p+1:2p
  input  wire logic [61:0] stuff_req_i,
  // Elastic store output bit per port, read after an extra clock
  input  wire logic [30:0] stuff_data_i,
  // Sampled channel bits, port p at bit p
  input  wire logic [30:0] sample_data_i,
  input  wire logic        sample_valid_i,
  output logic             sample_ready_o,
  // Serial stream with its bit, word, minor and major markers
  output logic             ser_o,
  output logic             bit_stb_o,
  output logic             word_stb_o,
  output logic             minor_stb_o,
  output logic             major_stb_o,
  // Gated clocks to the elastic stores, one pulse per bit
  output logic [30:0]      gclk_o,
  // Port served by the overhead word now going out
  output logic [4:0]       served_port_o,
  // High while the last data word found the buffer empty
  output logic             underrun_o
);
  // ==========================================================================
  // Sample buffer
  logic [30:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        fifo_in_ready;
  logic        ready_reg;
  tdm_fifo #(
    .WIDTH (tdm_pkg::MAX_PORTS),
    .DEPTH (tdm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_data_i   (sample_data_i),
    .in_valid_i  (sample_valid_i & ready_reg),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready)
  );

  // ==========================================================================
  // Bit rate divider
  logic [7:0] div_reg;
  logic [7:0] div_next;
  wire        div_wrap = (div_reg == 8'(tdm_pkg::BIT_DIV - 1));
  wire        bit_en   = div_wrap;
  assign div_next = div_wrap ? 8'h00 : div_reg + 8'h01;

  // ==========================================================================
  // Frame counters and latched state
  logic [4:0]  pos_reg;
  logic [4:0]  word_reg;
  logic [4:0]  minor_reg;
  logic [4:0]  nports_reg;
  logic [30:0] cur_reg;
  logic [1:0]  act_reg;
  logic        sense_reg;
  logic        under_reg;

  // Position 0 is the overhead bit; 1..N carry channel bits
  wire         last_pos   = (pos_reg == nports_reg);
  wire         last_word  = (word_reg == tdm_pkg::LAST_WORD);
  wire         last_minor = (minor_reg == tdm_pkg::LAST_MINOR);
  wire         oh_slot    = (pos_reg == 5'h00);

  // Port count clamped to the legal range; one extra overhead port added
  wire [4:0]   ports_in   = ch_ports_i;
  wire [4:0]   ports_ok   = (ports_in < tdm_pkg::PORTS_MIN_CODE) ? tdm_pkg::PORTS_MIN_CODE : ports_in;

  // Counter advance; ports wrap at N, words at 28, minors at 30
  wire [4:0]   pos_next   = last_pos ? 5'h00 : pos_reg + 5'h01;
  wire [4:0]   word_next  = !last_pos ? word_reg : (last_word ? 5'h00 : word_reg + 5'h01);
  wire         minor_step = last_pos & last_word;
  wire [4:0]   minor_next = !minor_step ? minor_reg
                          : (last_minor ? 5'h00 : minor_reg + 5'h01);
  wire         major_wrap = minor_step & last_minor;

  // Stuff request of the port served in this minor frame
  wire [5:0]   req_idx    = {minor_reg, 1'b0};
  wire [1:0]   req_sel    = stuff_req_i[req_idx +: 2];
  wire         frame_head = oh_slot & (word_reg == 5'h00);
  wire [1:0]   act_now    = frame_head ? req_sel : act_reg;
  wire         port_used  = (minor_reg < nports_reg);
  wire         pos_stuff  = (act_now == tdm_pkg::STUFF_POS) & port_used;

  // ==========================================================================
  // Overhead word assembly, bit 0 sent in data word 0
  logic [22:0] code_sel;
  always_comb begin
    unique case (act_now)
      tdm_pkg::STUFF_POS: code_sel = tdm_pkg::CODE_POS;
      tdm_pkg::STUFF_NEG: code_sel = tdm_pkg::CODE_NEG;
      default:            code_sel = tdm_pkg::CODE_NONE;
    endcase
  end
  // A reserved request is sent as no action, so the receiver never sees junk
  wire [28:0]  oh_word    = {sense_reg, minor_reg, code_sel};
  wire         oh_bit     = oh_word[word_reg];

  // ==========================================================================
  // Channel bit and gated clock selection
  wire [4:0]   ch_idx     = pos_reg - 5'h01;
  wire         ch_bit     = cur_reg[ch_idx];
  wire         ser_next   = oh_slot ? oh_bit : ch_bit;
  wire         drop_word  = (word_reg == tdm_pkg::CRC_DROP_WORD);
  wire         stuff_slot = oh_slot & (word_reg == tdm_pkg::STUFF_WORD);
  wire         sense_slot = (pos_reg == 5'h01) & (word_reg == tdm_pkg::STUFF_WORD);

  // One regular clock per sampled bit, none in the drop word for converted ports, plus the extra clock for positive stuff
  logic [30:0] gclk_next;
  genvar gp;
  generate
    for (gp = 0; gp < 31; gp++) begin : g_gclk
      wire reg_clk = bit_en & !oh_slot & (ch_idx == 5'(gp)) &
                     !(crc_en_i[gp] & drop_word);
      wire xtr_clk = bit_en & stuff_slot & pos_stuff & (minor_reg == 5'(gp));
      assign gclk_next[gp] = reg_clk | xtr_clk;
    end
  endgenerate

  // Pop one sample per data word while the overhead bit goes out
  assign fifo_ready = bit_en & oh_slot;

  // ==========================================================================
  // Bit rate divider runs free; every slower step is the bit_en pulse
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_next;
    end
  end

  // Port position in the word; the rate follows N+1 because pos wraps at N
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_reg <= 5'h00;
    end else if (bit_en) begin
      pos_reg <= pos_next;
    end
  end

  // Data word within the minor frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_reg <= 5'h00;
    end else if (bit_en) begin
      word_reg <= word_next;
    end
  end

  // Minor frame within the major frame; also the port being served
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      minor_reg <= 5'h00;
    end else if (bit_en) begin
      minor_reg <= minor_next;
    end
  end

  // ==========================================================================
  // Port count is only changed at a major frame boundary
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nports_reg <= tdm_pkg::PORTS_MAX_CODE;
    end else if (bit_en & major_wrap) begin
      nports_reg <= ports_ok;
    end
  end

  // ==========================================================================
  // Stuff action held for the whole minor frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_reg <= 2'h0;
    end else if (bit_en & frame_head) begin
      act_reg <= req_sel;
    end
  end

  // Sense bit: cleared at each frame head, then loaded from the store
  // one bit step after the extra clock, once the pulled bit has settled
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sense_reg <= 1'b0;
    end else if (bit_en & sense_slot & pos_stuff) begin
      sense_reg <= stuff_data_i[minor_reg];
    end else if (bit_en & frame_head) begin
      sense_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Current sample; an empty buffer sends zeros rather than stale data
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_reg <= 31'h0;
    end else if (fifo_ready) begin
      cur_reg <= fifo_valid ? fifo_data : 31'h0;
    end
  end

  // Underrun is judged once per data word, at the overhead slot
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      under_reg <= 1'b0;
    end else if (fifo_ready) begin
      under_reg <= !fifo_valid;
    end
  end

  // ==========================================================================
  // Sample occupancy, tracked here so the ready output can be a flip-flop
  // The buffer's own full flag only guards against overrun; this count is
  // exact, so the registered ready never promises a slot that is gone
  logic [4:0]  occ_reg;
  logic [4:0]  occ_next;
  wire         occ_push   = sample_valid_i & ready_reg & fifo_in_ready;
  wire         occ_pop    = fifo_ready & fifo_valid;
  wire [4:0]   occ_full   = 5'(tdm_pkg::FIFO_DEPTH);
  // Up and down in one cycle leave the count alone
  always_comb begin
    occ_next = occ_reg;
    if (occ_push & !occ_pop) begin
      occ_next = occ_reg + 5'h01;
    end else if (occ_pop & !occ_push) begin
      occ_next = occ_reg - 5'h01;
    end
  end
  // Ready looks one word ahead, so an offered word is never lost at full
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      occ_reg   <= 5'h00;
      ready_reg <= 1'b0;
    end else begin
      occ_reg   <= occ_next;
      ready_reg <= (occ_next != occ_full);
    end
  end

  // ==========================================================================
  // Registered outputs; every one of them comes straight from a flip-flop
  // Serial bit holds between bit steps
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ser_o <= 1'b0;
    end else if (bit_en) begin
      ser_o <= ser_next;
    end
  end

  // Strobe decode; the strobes leave one cycle after the step, as ser_o does
  wire         word_stb_next  = bit_en & oh_slot;
  wire         minor_stb_next = bit_en & frame_head;
  wire         major_stb_next = minor_stb_next & (minor_reg == 5'h00);

  // Bit strobe marks every new serial bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_stb_o <= 1'b0;
    end else begin
      bit_stb_o <= bit_en;
    end
  end

  // Word strobe marks the overhead bit at the head of each data word
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_stb_o <= 1'b0;
    end else begin
      word_stb_o <= word_stb_next;
    end
  end

  // Minor strobe marks overhead bit 0 of each minor frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      minor_stb_o <= 1'b0;
    end else begin
      minor_stb_o <= minor_stb_next;
    end
  end

  // Major strobe marks the first minor frame of each major frame
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      major_stb_o <= 1'b0;
    end else begin
      major_stb_o <= major_stb_next;
    end
  end

  // Gated clocks leave with the bit they belong to
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gclk_o <= 31'h0;
    end else begin
      gclk_o <= gclk_next;
    end
  end

  // Served port follows the minor frame counter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      served_port_o <= 5'h00;
    end else begin
      served_port_o <= minor_reg;
    end
  end

  // Underrun flag, one cycle behind its internal copy
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      underrun_o <= 1'b0;
    end else begin
      underrun_o <= under_reg;
    end
  end

  // Ready leaves the block straight from its flip-flop
  assign sample_ready_o = ready_reg;
endmodule
`default_nettype wire

// *** tdm_output_frame_formatter_assertions.sv ***
// Port checker for the output frame formatter
`timescale 1ns/1ns
`default_nettype none
module tdm_fmt_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [4:0]  ch_ports_i,
  input wire logic [30:0] gclk_o,
  input wire logic [4:0]  served_port_o,
  input wire logic        ser_o,
  input wire logic        bit_stb_o,
  input wire logic        word_stb_o,
  input wire logic        minor_stb_o,
  input wire logic        major_stb_o
);
  logic [5:0] nb_reg;
  logic [4:0] nw_reg;
  logic [4:0] mi_reg;
  logic [4:0] n_reg;
  // ==========================================================
  // Frame counters
  // Zero means no full unit seen yet, so a fresh reset never fires
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) begin
      nb_reg <= 6'h00;
      nw_reg <= 5'h00;
      mi_reg <= 5'h00;
      n_reg  <= 5'h1F;
    end else begin
      if (bit_stb_o) nb_reg <= word_stb_o ? 6'h01 : nb_reg + 6'h01;
      if (word_stb_o) nw_reg <= minor_stb_o ? 5'h01 : nw_reg + 5'h01;
      if (minor_stb_o) mi_reg <= major_stb_o ? 5'h01 : mi_reg + 5'h01;
      if (major_stb_o) n_reg <= (ch_ports_i < 5'h0F) ? 5'h0F : ch_ports_i;
    end
  // ==========================================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_bit_period: assert property (bit_stb_o |=> !bit_stb_o [*3] ##1 bit_stb_o)
    else $error("bit strobe spacing wrong");
  chk_word_on_bit: assert property (word_stb_o |-> bit_stb_o)
    else $error("word start without bit");
  chk_minor_on_word: assert property (minor_stb_o |-> word_stb_o)
    else $error("minor start off word");
  chk_major_on_minor: assert property (major_stb_o |-> minor_stb_o)
    else $error("major start off minor");
  chk_ser_hold: assert property (!bit_stb_o |-> $stable(ser_o))
    else $error("serial bit changed between strobes");
  chk_gclk_in_bit: assert property (|gclk_o |-> bit_stb_o)
    else $error("gated clock off bit step");
  chk_oh_no_clock: assert property (word_stb_o |-> (gclk_o & ~(31'h1 << served_port_o)) == 31'h0)
    else $error("clock issued in overhead slot");
  chk_word_length: assert property (word_stb_o && nb_reg != 6'h00 |-> nb_reg == {1'b0, n_reg} + 6'h01)
    else $error("word length wrong");
  chk_minor_length: assert property (minor_stb_o && nw_reg != 5'h00 |-> nw_reg == 5'h1D)
    else $error("minor frame length wrong");
  chk_major_length: assert property (major_stb_o && mi_reg != 5'h00 |-> mi_reg == 5'h1F)
    else $error("major frame length wrong");
  chk_served_order: assert property (minor_stb_o |-> served_port_o == (major_stb_o ? 5'h00 : mi_reg))
    else $error("served port out of order");
  cov_major: cover property (major_stb_o);
  cov_stuff_clock: cover property (word_stb_o && |gclk_o);
  cov_port3: cover property (minor_stb_o && served_port_o == 5'h03);
endmodule
bind tdm_output_frame_formatter tdm_fmt_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ch_ports_i(ch_ports_i),
  .gclk_o(gclk_o), .served_port_o(served_port_o), .ser_o(ser_o), .bit_stb_o(bit_stb_o),
  .word_stb_o(word_stb_o), .minor_stb_o(minor_stb_o), .major_stb_o(major_stb_o));
`default_nettype wire

// *** tdm_pkg.sv ***
// Constants and types shared by the output frame formatter and its FIFO
// ==========================================================================
// How it works
// - A major frame is exactly 31 consecutive minor frames.
// - A minor frame holds 29 data words and one full 29-bit overhead word.
// - Bit zero of every data word carries the next overhead bit.
// - One channel bit per port in use follows; 15 to 31 ports, words 16 to 32.
// - The 31 overhead words of a major frame each serve one of 31 ports.
// - Overhead bits 1 to 23 hold one of three stuff codes.
// - Overhead bits 24 to 28 hold the 5-bit number of the served port.
// - Positive stuff issues one extra gated clock to the served port.
// - The bit pulled by that extra clock goes out as overhead bit 29.
// - One extra port always carries overhead: total ports are N plus one.
// - Serial bit rate is port rate times total ports, overhead included.
// - Port rate is fixed per configuration and the same for all ports.
// - A channel takes 1 to 25 ports; all channel ports sum to N.
// - Coarse rate conversion withholds gated clocks in a fixed sequence.
// - Overhead bits are spread one per data word, never sent as a burst.
package tdm_pkg;
  localparam int unsigned MINORS_PER_MAJOR = 31;
  localparam int unsigned WORDS_PER_MINOR  = 29;
  localparam int unsigned MAX_PORTS        = 31;
  localparam int unsigned MIN_PORTS        = 15;
  localparam int unsigned CODE_BITS        = 23;
  localparam int unsigned PORTNUM_BITS     = 5;
  localparam int unsigned FIFO_DEPTH       = 16;
  // Cycles of clk_i per serial bit; the port rate follows from this and N+1
  localparam int unsigned BIT_DIV          = 4;
  // Data word of each minor frame in which converted ports lose their clock
  localparam logic [4:0]  CRC_DROP_WORD    = 5'h0E;
  // Word in which the extra stuff clock is issued, ahead of overhead bit 29
  localparam logic [4:0]  STUFF_WORD       = 5'h1B;
  localparam logic [4:0]  LAST_WORD        = 5'h1C;
  localparam logic [4:0]  LAST_MINOR       = 5'h1E;
  localparam logic [4:0]  PORTS_MIN_CODE   = 5'h0F;
  localparam logic [4:0]  PORTS_MAX_CODE   = 5'h1F;
  // Stuff codes, sent bit 0 first; distinct patterns for the receiver to find
  localparam logic [22:0] CODE_NONE        = 23'h3A5C93;
  localparam logic [22:0] CODE_POS         = 23'h0F3B61;
  localparam logic [22:0] CODE_NEG         = 23'h71C2DE;
  typedef enum logic [1:0] {STUFF_NONE, STUFF_POS, STUFF_NEG, STUFF_RSVD} stuff_t;
endpackage
